/* tpw_timer_pwm.sv */
// Eight-bit timer counter with fast and phase correct PWM waveform logic
//
// Added by the designer: strobed register access.
`include "tpw_defs.svh"

// Summary of operation
// - Selector 3 or 7 counts single-slope, BOTTOM up to TOP, then restart.
// - Single-slope TOP is 0xFF for selector 3, compare A for selector 7.
// - Single-slope counter increments to TOP, clears on the next tick.
// - Single-slope mode two clears output on match, sets it at BOTTOM.
// - Single-slope mode three sets output on match, clears it at BOTTOM.
// - Wrap-related output change happens in the TOP to BOTTOM tick.
// - Mode one toggles channel A on match only with mode high bit set.
// - Single-slope overflow flag sets on the tick that wraps TOP to BOTTOM.
// - Compare A at BOTTOM gives a spike; at MAX a constant level.
// - Compare writes are double buffered in the PWM modes.
// - Selector 1 or 5 counts dual-slope, up to TOP then down to BOTTOM.
// - Dual-slope TOP is 0xFF for selector 1, compare A for selector 5.
// - Dual-slope reverses at TOP and holds TOP for exactly one tick.
// - Dual-slope mode two clears on up match, sets on down match.
// - Dual-slope overflow flag sets on the tick that turns the count up at BOTTOM.
// - Dual-slope compare A at BOTTOM holds low, at MAX holds high.
// - Leaving MAX, output at TOP takes the up-count match result.
// - A missed up-count match still yields its transition at TOP.
// - Synchronous to mclk except for the asynchronous reset; the timer tick is an enable, not a clock.
// - Control A at 0x24: out modes 7:6 and 5:4, wave mode 1:0, reset 0.
// - Control A bits 3 and 2 always read zero.
// - Mode high bit sits in control B, joined with low bits.
// - Compare equal TOP with mode bit 1 set: match ignored, act at TOP.
module tpw_timer_pwm (
  input wire logic mclk,
  input wire logic rst,
  input wire tpw_pkg::tpw_bus_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic timer_tick,
  input wire tpw_pkg::tpw_port_t port_ctl,
  output tpw_pkg::tpw_pin_t pin,
  output logic [1:0] wave_out,
  output logic overflow_flag
);
  import tpw_pkg::*;

  tpw_state_t s;
  tpw_state_t n;

  logic [2:0] waveform_mode_sel;
  logic mode_fast;
  logic mode_pc;
  logic mode_pwm;
  logic [7:0] top_val;
  logic [7:0] top_new;
  logic at_top;
  logic at_bot;
  logic wr_ctl_a;
  logic wr_ctl_b;
  logic wr_cnt;
  logic wr_flags;
  logic tick_run;
  logic [1:0] wr_cmp;
  logic [1:0] cmp_match;
  logic [1:0] connected;
  logic [1:0] wave_nx;

  assign waveform_mode_sel = {s.wm_high, s.ctl_a[`TPW_WML_LSB +: 2]};
  assign mode_fast = (waveform_mode_sel == `TPW_MODE_FAST_FIX) ||
                     (waveform_mode_sel == `TPW_MODE_FAST_VAR);
  assign mode_pc = (waveform_mode_sel == `TPW_MODE_PC_FIX) ||
                   (waveform_mode_sel == `TPW_MODE_PC_VAR);
  assign mode_pwm = mode_fast || mode_pc;
  assign top_val = s.wm_high ? s.cmp_act[0] : `TPW_TOP_MAX;
  // TOP as it stands after the reload that happens at TOP
  assign top_new = s.wm_high ? s.cmp_buf[0] : `TPW_TOP_MAX;
  assign at_top = (s.cnt == top_val);
  assign at_bot = (s.cnt == `TPW_BOTTOM);

  assign wr_ctl_a = reg_req.wr && (reg_req.addr == `TPW_ADDR_CTL_A);
  assign wr_ctl_b = reg_req.wr && (reg_req.addr == `TPW_ADDR_CTL_B);
  assign wr_cnt = reg_req.wr && (reg_req.addr == `TPW_ADDR_COUNT);
  assign wr_flags = reg_req.wr && (reg_req.addr == `TPW_ADDR_FLAGS);
  assign wr_cmp[0] = reg_req.wr && (reg_req.addr == `TPW_ADDR_CMP_A);
  assign wr_cmp[1] = reg_req.wr && (reg_req.addr == `TPW_ADDR_CMP_B);
  // A software count write wins over the tick and blocks the next match
  assign tick_run = timer_tick && !wr_cnt;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      localparam int OM_LSB = (gi == 0) ? `TPW_OMA_LSB : `TPW_OMB_LSB;
      logic [1:0] om;
      logic cmp_is_top;
      logic cmp_new_top;
      logic may_toggle;
      assign om = s.ctl_a[OM_LSB +: 2];
      assign cmp_is_top = (s.cmp_act[gi] == top_val);
      assign cmp_new_top = (s.cmp_buf[gi] == top_new);
      // Toggle exists on channel A only
      assign may_toggle = (gi == 0) && (om == `TPW_OM_TOGGLE) && s.wm_high;
      assign cmp_match[gi] = tick_run && !s.blk &&
                             (s.cnt == s.cmp_act[gi]);
      assign connected[gi] = (om != `TPW_OM_OFF);

      always_comb begin
        wave_nx[gi] = s.wave[gi];
        if (tick_run && mode_fast) begin
          if (om[1] && cmp_match[gi] && !cmp_is_top) begin
            wave_nx[gi] = om[0];
          end
          if (may_toggle && cmp_match[gi]) begin
            wave_nx[gi] = ~s.wave[gi];
          end
          if (om[1] && at_top) begin
            wave_nx[gi] = ~om[0];
          end
        end else if (tick_run && mode_pc) begin
          if (om[1] && cmp_match[gi] && !cmp_is_top) begin
            // The BOTTOM turnaround counts as part of the up slope
            if (s.cnt_down && !at_bot) begin
              wave_nx[gi] = ~om[0];
            end else begin
              wave_nx[gi] = om[0];
            end
          end
          if (may_toggle && cmp_match[gi]) begin
            wave_nx[gi] = ~s.wave[gi];
          end
          if (om[1] && at_top && !s.cnt_down) begin
            // Restore the up-slope level so the period is symmetric
            if (cmp_new_top) begin
              wave_nx[gi] = ~om[0];
            end else begin
              wave_nx[gi] = om[0];
            end
          end
        end
      end
    end
  endgenerate

  always_comb begin
    n = s;
    n.rdata = 8'h00;
    n.wave = wave_nx;

    if (wr_ctl_a) begin
      n.ctl_a = reg_req.wdata & `TPW_CTL_A_RMASK;
    end
    if (wr_ctl_b) begin
      n.wm_high = reg_req.wdata[0];
    end
    for (int i = 0; i < 2; i++) begin
      if (wr_cmp[i]) begin
        n.cmp_buf[i] = reg_req.wdata;
      end
    end

    if (wr_cnt) begin
      n.cnt = reg_req.wdata;
      n.blk = 1'b1;
    end else if (timer_tick) begin
      n.blk = 1'b0;
      if (mode_fast) begin
        if (at_top) begin
          n.cnt = `TPW_BOTTOM;
        end else begin
          n.cnt = s.cnt + 8'h01;
        end
      end else if (mode_pc) begin
        if (!s.cnt_down) begin
          if (at_top) begin
            n.cnt_down = 1'b1;
            n.cnt = s.cnt - 8'h01;
          end else begin
            n.cnt = s.cnt + 8'h01;
          end
        end else if (at_bot) begin
          n.cnt_down = 1'b0;
          n.cnt = s.cnt + 8'h01;
        end else begin
          n.cnt = s.cnt - 8'h01;
        end
      end else begin
        // Non-PWM modes are out of scope; free-run upward
        n.cnt = s.cnt + 8'h01;
      end
    end
    if (!mode_pc) begin
      n.cnt_down = 1'b0;
    end

    // Reload at TOP; outside PWM the active compare follows writes at once
    if (!mode_pwm) begin
      n.cmp_act = n.cmp_buf;
    end else if (tick_run && at_top && !s.cnt_down) begin
      n.cmp_act = s.cmp_buf;
    end

    // Software clears with a one; a same-cycle set wins
    if (wr_flags && reg_req.wdata[`TPW_FLAG_OVF]) begin
      n.ovf = 1'b0;
    end
    // The start-up pass through BOTTOM while counting up is no overflow
    if (tick_run && ((mode_fast && at_top) ||
                     (mode_pc && s.cnt_down && at_bot))) begin
      n.ovf = 1'b1;
    end

    for (int i = 0; i < 2; i++) begin
      n.pin.out[i] = connected[i] ? wave_nx[i] : port_ctl.port_val[i];
      n.pin.oe[i] = port_ctl.dir[i];
    end

    if (reg_req.rd) begin
      case (reg_req.addr)
        `TPW_ADDR_CTL_A: n.rdata = s.ctl_a & `TPW_CTL_A_RMASK;
        `TPW_ADDR_CTL_B: n.rdata = {7'h00, s.wm_high};
        `TPW_ADDR_COUNT: n.rdata = s.cnt;
        `TPW_ADDR_CMP_A: n.rdata = s.cmp_buf[0];
        `TPW_ADDR_CMP_B: n.rdata = s.cmp_buf[1];
        `TPW_ADDR_FLAGS: n.rdata = {7'h00, s.ovf};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign pin = s.pin;
  assign wave_out = s.wave;
  assign overflow_flag = s.ovf;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_fast_top_tick;
    mode_fast && tick_run && at_top;
  endsequence

  sequence s_pc_up_at_top;
    mode_pc && tick_run && !s.cnt_down && at_top;
  endsequence

  sequence s_pc_down_at_bot;
    mode_pc && tick_run && s.cnt_down && at_bot;
  endsequence

  a_fast_wrap_bottom:
    assert property (s_fast_top_tick |=> s.cnt == `TPW_BOTTOM)
    else $error("fast mode did not wrap to bottom after TOP");

  a_fast_count_up:
    assert property (mode_fast && tick_run && !at_top && !wr_cnt
                     |=> s.cnt == $past(s.cnt) + 8'h01)
    else $error("fast mode count did not increment");

  a_fast_var_top:
    assert property (waveform_mode_sel == `TPW_MODE_FAST_VAR && tick_run &&
                     s.cnt == s.cmp_act[0] |=> s.cnt == `TPW_BOTTOM)
    else $error("selector 7 did not wrap at compare A");

  a_fast_set_wrap:
    assert property (s_fast_top_tick ##0
                     s.ctl_a[`TPW_OMA_LSB +: 2] == `TPW_OM_NONINV
                     |=> s.wave[0] && s.cnt == `TPW_BOTTOM)
    else $error("non-inverted output not set at bottom");

  a_fast_inv_match:
    assert property (mode_fast && cmp_match[1] && !at_top &&
                     s.ctl_a[`TPW_OMB_LSB +: 2] == `TPW_OM_INV
                     |=> s.wave[1])
    else $error("inverted output B not set on match");

  a_fast_ovf_top:
    assert property (s_fast_top_tick |=> s.ovf)
    else $error("overflow not set at TOP in fast mode");

  a_pc_hold_top:
    assert property (s_pc_up_at_top ##1 (!timer_tick && !wr_cnt) [*2]
                     |=> s.cnt_down && s.cnt == $past(s.cnt, 3) - 8'h01)
    else $error("dual-slope did not turn and leave TOP");

  a_pc_turn_bottom:
    assert property (s_pc_down_at_bot |=> !s.cnt_down &&
                     s.cnt == 8'h01)
    else $error("dual-slope did not turn at bottom");

  a_pc_ovf_bottom:
    assert property (s_pc_down_at_bot |=> s.ovf)
    else $error("overflow not set at bottom in dual-slope");

  a_pc_down_match:
    assert property (mode_pc && cmp_match[1] && s.cnt_down && !at_bot &&
                     !(s.cmp_act[1] == top_val) &&
                     s.ctl_a[`TPW_OMB_LSB +: 2] == `TPW_OM_NONINV
                     |=> s.wave[1])
    else $error("dual-slope down match did not set output");

  a_cmp_buffered:
    assert property (mode_fast && wr_cmp[0] && !(tick_run && at_top)
                     |=> s.cmp_act[0] == $past(s.cmp_act[0]))
    else $error("compare A changed before TOP in fast mode");

  a_ctl_rsv_zero:
    assert property (reg_req.rd && reg_req.addr == `TPW_ADDR_CTL_A
                     |=> reg_rdata[3:2] == 2'h0)
    else $error("reserved control bits read nonzero");

  a_pin_release:
    assert property (!connected[0] |=> pin.out[0] ==
                     $past(port_ctl.port_val[0]) &&
                     pin.oe[0] == $past(port_ctl.dir[0]))
    else $error("disconnected pin not left to port logic");

  a_ovf_set_wins:
    assert property (s_fast_top_tick ##0
                     (wr_flags && reg_req.wdata[`TPW_FLAG_OVF])
                     |=> s.ovf)
    else $error("overflow clear beat a same-cycle set");

  a_fast_clr_match:
    assert property (mode_fast && cmp_match[0] && !at_top &&
                     s.ctl_a[`TPW_OMA_LSB +: 2] == `TPW_OM_NONINV
                     |=> !s.wave[0])
    else $error("non-inverted output A not cleared on match");

  a_fast_inv_wrap:
    assert property (s_fast_top_tick ##0
                     (s.ctl_a[`TPW_OMB_LSB +: 2] == `TPW_OM_INV)
                     |=> !s.wave[1])
    else $error("inverted output B not cleared at bottom");

  a_pc_up_match:
    assert property (mode_pc && cmp_match[0] && !s.cnt_down &&
                     s.cmp_act[0] != top_val &&
                     s.ctl_a[`TPW_OMA_LSB +: 2] == `TPW_OM_INV
                     |=> s.wave[0])
    else $error("inverted output A not set on up match");

  a_pc_top_sym:
    assert property (s_pc_up_at_top ##0
                     (s.ctl_a[`TPW_OMA_LSB +: 2] == `TPW_OM_NONINV &&
                      s.cmp_buf[0] != top_new)
                     |=> !s.wave[0])
    else $error("output A at TOP not at its up-match level");

  a_pc_max_level:
    assert property (s_pc_up_at_top ##0
                     (s.ctl_a[`TPW_OMA_LSB +: 2] == `TPW_OM_NONINV &&
                      s.cmp_buf[0] == top_new)
                     |=> s.wave[0])
    else $error("compare A at MAX did not hold output high");

  a_pc_var_top:
    assert property (waveform_mode_sel == `TPW_MODE_PC_VAR && tick_run &&
                     !s.cnt_down && s.cnt == s.cmp_act[0] |=> s.cnt_down)
    else $error("selector 5 did not turn at compare A");

  a_toggle_a:
    assert property (mode_pwm && s.wm_high && cmp_match[0] &&
                     s.ctl_a[`TPW_OMA_LSB +: 2] == `TPW_OM_TOGGLE
                     |=> s.wave[0] != $past(s.wave[0]))
    else $error("channel A did not toggle on match");

  a_no_toggle_b:
    assert property (mode_pwm && tick_run &&
                     s.ctl_a[`TPW_OMB_LSB +: 2] == `TPW_OM_TOGGLE
                     |=> s.wave[1] == $past(s.wave[1]))
    else $error("channel B changed in its reserved mode");

  a_cnt_write:
    assert property (wr_cnt |=> s.cnt == $past(reg_req.wdata))
    else $error("count write not taken");

  a_top_reload:
    assert property (s_fast_top_tick |=> s.cmp_act == $past(s.cmp_buf))
    else $error("compare not reloaded at TOP");

endmodule : tpw_timer_pwm

/* tpw_defs.svh */
// Register offsets, field positions, reset values and fixed counts
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH

`define TPW_ADDR_CTL_A 8'h24
`define TPW_ADDR_CTL_B 8'h25
`define TPW_ADDR_COUNT 8'h26
`define TPW_ADDR_CMP_A 8'h27
`define TPW_ADDR_CMP_B 8'h28
`define TPW_ADDR_FLAGS 8'h29

`define TPW_CTL_A_RST 8'h00
`define TPW_CTL_A_RMASK 8'hF3
`define TPW_OMA_LSB 6
`define TPW_OMB_LSB 4
`define TPW_WML_LSB 0
`define TPW_FLAG_OVF 0

`define TPW_TOP_MAX 8'hFF
`define TPW_BOTTOM 8'h00
`define TPW_MODE_FAST_FIX 3'h3
`define TPW_MODE_FAST_VAR 3'h7
`define TPW_MODE_PC_FIX 3'h1
`define TPW_MODE_PC_VAR 3'h5
`define TPW_OM_OFF 2'h0
`define TPW_OM_TOGGLE 2'h1
`define TPW_OM_NONINV 2'h2
`define TPW_OM_INV 2'h3

`endif

/* tpw_pkg.sv */
// Types shared by the timer PWM waveform block
package tpw_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpw_bus_req_t;

  // Index 0 is channel A, index 1 is channel B
  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] port_val;
  } tpw_port_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } tpw_pin_t;

  typedef struct packed {
    logic [7:0] ctl_a;
    logic wm_high;
    logic [7:0] cnt;
    logic cnt_down;
    logic [1:0][7:0] cmp_act;
    logic [1:0][7:0] cmp_buf;
    logic ovf;
    logic [1:0] wave;
    logic blk;
    logic [7:0] rdata;
    tpw_pin_t pin;
  } tpw_state_t;

endpackage : tpw_pkg

/* tpw_testbench.sv */
// Self-checking bench for the timer PWM waveform block
`include "tpw_defs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tpw_pkg::*;

  logic mclk;
  logic rst;
  tpw_bus_req_t reg_req;
  logic [7:0] reg_rdata;
  logic timer_tick;
  tpw_port_t port_ctl;
  tpw_pin_t pin;
  logic [1:0] wave_out;
  logic overflow_flag;
  int fails;
  int num_checks;
  logic [7:0] d;

  tpw_timer_pwm tpw_timer_pwm_inst (
    .mclk(mclk),
    .rst(rst),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .timer_tick(timer_tick),
    .port_ctl(port_ctl),
    .pin(pin),
    .wave_out(wave_out),
    .overflow_flag(overflow_flag)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic do_reset;
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge mclk);
    reg_req <= '0;
    // Let the write settle before any output is looked at
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk);
    reg_req <= '0;
    #1 v = reg_rdata;
  endtask : rd

  // One tick per cycle, back to back
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      timer_tick <= 1'b1;
    end
    @(posedge mclk);
    timer_tick <= 1'b0;
    #1;
  endtask : tick

  task automatic cnt_is(input logic [7:0] exp);
    rd(`TPW_ADDR_COUNT, d);
    chk("count", d, exp);
  endtask : cnt_is

  // Hang guard well beyond the longest sequence
  initial begin
    #(20000 * 25);
    fails++;
    end_sim();
  end

  initial begin
    fails = 0;
    num_checks = 0;
    rst = 1'b1;
    reg_req = '0;
    timer_tick = 1'b0;
    port_ctl = '{dir: 2'b11, port_val: 2'b10};
    do_reset();
    // Register reset, reserved bits, unmapped place, port fallback
    rd(`TPW_ADDR_CTL_A, d);
    chk("ctl_a reset", d, 8'h00);
    chk("pin out port", {6'h00, pin.out}, 8'h02);
    chk("pin oe", {6'h00, pin.oe}, 8'h03);
    wr(`TPW_ADDR_CTL_A, 8'hFF);
    rd(`TPW_ADDR_CTL_A, d);
    chk("ctl_a reserved", d, 8'hF3);
    rd(8'h30, d);
    chk("unmapped", d, 8'h00);
    $display("test registers done");

    // Fast PWM, fixed TOP, A non-inverting, B inverting
    do_reset();
    wr(`TPW_ADDR_CMP_A, 8'h02);
    wr(`TPW_ADDR_CMP_B, 8'h02);
    wr(`TPW_ADDR_CTL_A, 8'hB3);
    tick(3);
    chk("wave match", {6'h00, wave_out}, 8'h02);
    tick(252);
    cnt_is(8'hFF);
    chk("wave at top", {6'h00, wave_out}, 8'h02);
    chk("ovf early", {7'h00, overflow_flag}, 8'h00);
    tick(1);
    chk("wave wrap", {6'h00, wave_out}, 8'h01);
    chk("ovf top", {7'h00, overflow_flag}, 8'h01);
    chk("pin out wave", {6'h00, pin.out}, 8'h01);
    cnt_is(8'h00);
    cnt_is(8'h00);
    wr(`TPW_ADDR_FLAGS, 8'h01);
    chk("ovf clear", {7'h00, overflow_flag}, 8'h00);
    wr(`TPW_ADDR_COUNT, 8'hFF);
    fork
      tick(1);
      wr(`TPW_ADDR_FLAGS, 8'h01);
    join
    chk("ovf set wins", {7'h00, overflow_flag}, 8'h01);
    cnt_is(8'h00);
    $display("test fast done");

    // Fast PWM, TOP from compare A, toggle, buffered compare
    do_reset();
    wr(`TPW_ADDR_CMP_A, 8'h02);
    wr(`TPW_ADDR_CTL_A, 8'h53);
    wr(`TPW_ADDR_CTL_B, 8'h01);
    tick(3);
    cnt_is(8'h00);
    chk("toggle 1", {7'h00, wave_out[0]}, 8'h01);
    chk("ovf var top", {7'h00, overflow_flag}, 8'h01);
    wr(`TPW_ADDR_CMP_A, 8'h05);
    tick(3);
    cnt_is(8'h00);
    chk("toggle 2", {7'h00, wave_out[0]}, 8'h00);
    tick(5);
    cnt_is(8'h05);
    tick(1);
    cnt_is(8'h00);
    chk("toggle 3", {7'h00, wave_out[0]}, 8'h01);
    // Without the high mode bit, mode one takes no action
    wr(`TPW_ADDR_CTL_B, 8'h00);
    tick(6);
    cnt_is(8'h06);
    chk("no toggle", {7'h00, wave_out[0]}, 8'h01);
    $display("test toggle done");

    // Narrow spike with compare A at BOTTOM
    do_reset();
    wr(`TPW_ADDR_CMP_A, 8'h00);
    wr(`TPW_ADDR_CTL_A, 8'h83);
    tick(256);
    chk("spike high", {7'h00, wave_out[0]}, 8'h01);
    tick(1);
    chk("spike low", {7'h00, wave_out[0]}, 8'h00);
    $display("test spike done");

    // Phase correct, fixed TOP, A inverting, B non-inverting
    do_reset();
    wr(`TPW_ADDR_CMP_A, 8'h80);
    wr(`TPW_ADDR_CMP_B, 8'h40);
    wr(`TPW_ADDR_CTL_A, 8'hE1);
    tick(128);
    chk("pc before up", {7'h00, wave_out[0]}, 8'h00);
    tick(1);
    chk("pc up match", {7'h00, wave_out[0]}, 8'h01);
    tick(126);
    cnt_is(8'hFF);
    tick(1);
    cnt_is(8'hFE);
    chk("pc at top", {7'h00, wave_out[0]}, 8'h01);
    tick(126);
    chk("pc before dn", {7'h00, wave_out[0]}, 8'h01);
    tick(1);
    chk("pc dn match", {7'h00, wave_out[0]}, 8'h00);
    tick(127);
    cnt_is(8'h00);
    chk("pc ovf early", {7'h00, overflow_flag}, 8'h00);
    tick(1);
    chk("pc ovf", {7'h00, overflow_flag}, 8'h01);
    cnt_is(8'h01);
    chk("pc b dn match", {7'h00, wave_out[1]}, 8'h01);
    $display("test phase correct done");

    // Phase correct, compare A at MAX, then moved away from MAX
    do_reset();
    wr(`TPW_ADDR_CMP_A, 8'hFF);
    wr(`TPW_ADDR_CTL_A, 8'h81);
    tick(256);
    chk("pc max high", {7'h00, wave_out[0]}, 8'h01);
    tick(300);
    chk("pc max hold", {7'h00, wave_out[0]}, 8'h01);
    wr(`TPW_ADDR_CMP_A, 8'h10);
    tick(209);
    cnt_is(8'hFF);
    chk("pc leave max", {7'h00, wave_out[0]}, 8'h01);
    tick(1);
    chk("pc sym edge", {7'h00, wave_out[0]}, 8'h00);
    $display("test phase correct max done");
    end_sim();
  end
endmodule : testbench
